// File: hdl/wrx_pkt_arb.sv
`include "wrx_defs.svh"

module wrx_pkt_arb (
	// Pending packets, one per slot
	input  wire logic [`WRX_REQ_N-1:0] req,
	// Winning packet kind
	output wrx_pkg::wrx_pkt_e          kind
);
	import wrx_pkg::*;

	logic [`WRX_REQ_N-1:0] grant;

	// ============================================================
	// Fixed priority, lowest slot first
	genvar i;
	generate
		for (i = 0; i < `WRX_REQ_N; i++) begin : g_pri
			if (i == 0) begin : g_top
				assign grant[i] = req[i];
			end else begin : g_low
				assign grant[i] = req[i] & ~(|req[i-1:0]); // [R9]
			end
		end
	endgenerate

	always_comb begin
		kind = PK_NONE;
		if (grant[`WRX_REQ_EPT])
			kind = PK_EPT;
		if (grant[`WRX_REQ_RPP])
			kind = PK_RPP;
		if (grant[`WRX_REQ_CSP])
			kind = PK_CSP;
		if (grant[`WRX_REQ_PPP])
			kind = PK_PPP;
		if (grant[`WRX_REQ_CEP])
			kind = PK_CEP;
	end

endmodule

// File: hdl/wrx_regs.sv
`include "wrx_defs.svh"

module wrx_regs (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	// Host register port
	input  wire wrx_pkg::wrx_host_bus_s host_bus,
	output logic [7:0]                 host_rdata,
	// Measured device state
	input  wire logic [15:0]           coil_freq_khz,
	input  wire logic                  ac_present,
	input  wire logic [11:0]           die_temp_code,
	input  wire logic [15:0]           vrect_mv,
	// Stored packet contents
	input  wire logic [7:0]            charge_value,
	input  wire logic [7:0]            ept_reason,
	input  wire logic [7:0]            prop_cmd,
	input  wire logic [7:0]            prop_value,
	// Firmware packet requests
	input  wire logic                  rpp_req,
	input  wire logic [7:0]            rpp_value,
	input  wire logic                  cep_req,
	input  wire logic [7:0]            cep_value,
	output logic                       rpp_ack,
	output logic                       cep_ack,
	// Transmitter side
	output wrx_pkg::wrx_tx_pkt_s       tx_pkt,
	input  wire logic                  tx_ready,
	// Power and interrupt control
	output logic                       output_active_flag,
	output logic                       dc_load_en,
	output logic [2:0]                 overvoltage_threshold,
	output logic                       int_clear_go
);
	import wrx_pkg::*;

	wrx_state_s            st_reg;
	wrx_state_s            st_next;
	logic [`WRX_REQ_N-1:0] req;
	wrx_pkt_e              arb_kind;
	logic                  chg_ok;
	logic                  ept_ok;
	logic [1:0]            mode;
	logic [15:0]           ov_mv;
	logic                  wr_hit_mode;

	// ============================================================
	// Decoded inputs
	function automatic logic [15:0] ov_level(input logic [2:0] sel);
		case (sel)
			3'h0:    ov_level = `WRX_OV_MV_0;
			3'h1:    ov_level = `WRX_OV_MV_1;
			3'h2:    ov_level = `WRX_OV_MV_2;
			3'h3:    ov_level = `WRX_OV_MV_3;
			default: ov_level = `WRX_OV_MV_LOW;
		endcase
	endfunction

	// Reserved charge codes would mislead the transmitter, so none is sent
	assign chg_ok = (charge_value >= `WRX_CHG_MIN) &&
		(charge_value <= `WRX_CHG_MAX); // [R14]
	assign ept_ok = (ept_reason <= `WRX_EPT_MAX); // [R15]
	assign mode = ac_present ? `WRX_MODE_WPC : `WRX_MODE_AC_MISSING; // [R2]
	assign ov_mv = ov_level(st_reg.ov_sel); // [R12]
	assign wr_hit_mode = host_bus.wr_en && (host_bus.addr == `WRX_ADDR_MODE);

	// ============================================================
	// Pending packets; acks mask firmware requests for one cycle
	always_comb begin
		req = '0;
		req[`WRX_REQ_EPT] = st_reg.cmd[`WRX_CMD_EPT];
		req[`WRX_REQ_RPP] = rpp_req && !st_reg.rpp_ack;
		req[`WRX_REQ_CSP] = st_reg.cmd[`WRX_CMD_CSP] && chg_ok;
		req[`WRX_REQ_PPP] = st_reg.cmd[`WRX_CMD_PPP];
		req[`WRX_REQ_CEP] = cep_req && !st_reg.cep_ack;
	end

	wrx_pkt_arb u_arb (
		.req  (req),
		.kind (arb_kind)
	);

	// ============================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.int_clr = 1'b0;
		st_next.rpp_ack = 1'b0;
		st_next.cep_ack = 1'b0;

		// Command completions come first so that a host set wins
		if (st_reg.cmd[`WRX_CMD_CLR_INT]) begin
			st_next.int_clr = 1'b1; // [R4]
			st_next.cmd[`WRX_CMD_CLR_INT] = 1'b0; // [R4]
		end
		if (st_reg.cmd[`WRX_CMD_TOGGLE]) begin
			st_next.out_on = ~st_reg.out_on; // [R7]
			st_next.cmd[`WRX_CMD_TOGGLE] = 1'b0; // [R7]
		end
		if (st_reg.cmd[`WRX_CMD_CSP] && !chg_ok)
			st_next.cmd[`WRX_CMD_CSP] = 1'b0; // [R14]

		unique case (st_reg.tx_st)
			TX_IDLE: begin
				if (|req) begin
					st_next.tx.valid = 1'b1;
					st_next.tx.kind = arb_kind; // [R9]
					st_next.tx.hdr = 8'h00;
					st_next.tx_st = TX_BUSY;
					case (arb_kind)
						PK_EPT: st_next.tx.pay = ept_ok ? ept_reason :
							`WRX_EPT_UNKNOWN; // [R6] [R15]
						PK_RPP: st_next.tx.pay = rpp_value;
						PK_CSP: st_next.tx.pay = charge_value; // [R5]
						PK_PPP: begin
							st_next.tx.hdr = prop_cmd; // [R8]
							st_next.tx.pay = prop_value; // [R8]
						end
						PK_CEP: st_next.tx.pay = cep_value;
						default: st_next.tx.pay = 8'h00;
					endcase
				end
			end
			TX_BUSY: begin
				// Command bit drops only once the packet is taken
				if (tx_ready) begin
					st_next.tx.valid = 1'b0;
					st_next.tx_st = TX_IDLE;
					case (st_reg.tx.kind)
						PK_EPT: st_next.cmd[`WRX_CMD_EPT] = 1'b0; // [R6]
						PK_CSP: st_next.cmd[`WRX_CMD_CSP] = 1'b0; // [R5]
						PK_PPP: st_next.cmd[`WRX_CMD_PPP] = 1'b0; // [R8]
						PK_RPP: st_next.rpp_ack = 1'b1;
						PK_CEP: st_next.cep_ack = 1'b1;
						default: st_next.tx.valid = 1'b0;
					endcase
				end
			end
		endcase

		// Host writes; command bits can only be set from the host
		if (host_bus.wr_en) begin
			case (host_bus.addr)
				`WRX_ADDR_MODE:
					st_next.out_on = host_bus.wdata[0]; // [R3]
				`WRX_ADDR_CMD:
					st_next.cmd = st_next.cmd |
						(host_bus.wdata & `WRX_CMD_WMASK);
				`WRX_ADDR_OV:
					st_next.ov_sel = host_bus.wdata[2:0]; // [R12]
				default: st_next.cmd = st_next.cmd;
			endcase
		end

		// Host reads answer one edge later; unmapped reads give zero
		if (host_bus.rd_en) begin
			case (host_bus.addr)
				`WRX_ADDR_FREQ_L: st_next.rdata = coil_freq_khz[7:0]; // [R1]
				`WRX_ADDR_FREQ_H: st_next.rdata = coil_freq_khz[15:8]; // [R1]
				`WRX_ADDR_MODE:
					st_next.rdata = {1'b0, mode, 4'h0, st_reg.out_on}; // [R2] [R3]
				`WRX_ADDR_CMD:    st_next.rdata = st_reg.cmd;
				`WRX_ADDR_TEMP_L: st_next.rdata = die_temp_code[7:0]; // [R11]
				`WRX_ADDR_TEMP_H:
					st_next.rdata = {4'h0, die_temp_code[11:8]}; // [R11]
				`WRX_ADDR_OV:     st_next.rdata = {5'h00, st_reg.ov_sel};
				default:          st_next.rdata = 8'h00;
			endcase
		end

		// Extra load engages at nine tenths of the chosen level
		st_next.dc_load = (({4'h0, vrect_mv} * `WRX_DCL_DEN) >=
			({4'h0, ov_mv} * `WRX_DCL_NUM)); // [R13]
	end

	// ============================================================
	// State register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.cmd <= `WRX_CMD_RST;
			st_reg.ov_sel <= `WRX_OV_RST; // [R12]
			st_reg.tx_st <= TX_IDLE;
			st_reg.tx.kind <= PK_NONE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ============================================================
	// Outputs
	assign host_rdata = st_reg.rdata;
	assign rpp_ack = st_reg.rpp_ack;
	assign cep_ack = st_reg.cep_ack;
	assign tx_pkt = st_reg.tx;
	assign output_active_flag = st_reg.out_on;
	assign dc_load_en = st_reg.dc_load;
	assign overvoltage_threshold = st_reg.ov_sel;
	assign int_clear_go = st_reg.int_clr;

	// ============================================================
	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	a_freq_read: assert property ( // [R1]
		host_bus.rd_en && host_bus.addr == `WRX_ADDR_FREQ_H |=>
			host_rdata == $past(coil_freq_khz[15:8]))
		else $error("frequency high byte read wrong");

	a_mode_read: assert property ( // [R2]
		host_bus.rd_en && host_bus.addr == `WRX_ADDR_MODE |=>
			host_rdata[6:5] == ($past(ac_present) ? 2'h1 : 2'h0) &&
			host_rdata[0] == $past(output_active_flag))
		else $error("mode register read wrong");

	a_clr_int_pulse: assert property ( // [R4]
		st_reg.cmd[`WRX_CMD_CLR_INT] |=> int_clear_go ##1 !int_clear_go)
		else $error("interrupt clear not a single pulse");

	a_csp_done: assert property ( // [R5]
		tx_pkt.valid && tx_ready && tx_pkt.kind == PK_CSP &&
		!host_bus.wr_en |=> !st_reg.cmd[`WRX_CMD_CSP] && !tx_pkt.valid)
		else $error("charge status command not cleared");

	a_ept_payload: assert property ( // [R6]
		st_reg.tx_st == TX_IDLE && st_reg.cmd[`WRX_CMD_EPT] |=>
			tx_pkt.valid && tx_pkt.kind == PK_EPT &&
			(tx_pkt.pay <= 8'h08))
		else $error("end of power packet not sent first");

	a_toggle_once: assert property ( // [R7]
		st_reg.cmd[`WRX_CMD_TOGGLE] && !wr_hit_mode |=>
			output_active_flag != $past(output_active_flag) &&
			!st_reg.cmd[`WRX_CMD_TOGGLE])
		else $error("output toggle wrong");

	a_ppp_header: assert property ( // [R8]
		st_reg.tx_st == TX_IDLE && arb_kind == PK_PPP |=>
			tx_pkt.hdr == $past(prop_cmd) && tx_pkt.pay == $past(prop_value))
		else $error("proprietary packet contents wrong");

	a_rpp_first: assert property ( // [R9]
		st_reg.tx_st == TX_IDLE && req[`WRX_REQ_RPP] &&
		!req[`WRX_REQ_EPT] |=> tx_pkt.kind == PK_RPP)
		else $error("received power packet lost priority");

	a_tx_hold: assert property ( // [R9]
		tx_pkt.valid && !tx_ready |=> tx_pkt.valid && $stable(tx_pkt))
		else $error("packet changed before it was taken");

	a_temp_high: assert property ( // [R11]
		host_bus.rd_en && host_bus.addr == `WRX_ADDR_TEMP_H |=>
			host_rdata[7:4] == 4'h0 &&
			host_rdata[3:0] == $past(die_temp_code[11:8]))
		else $error("die temperature high byte wrong");

	a_ov_reset: assert property ( // [R12]
		$past(sys_rst) |-> overvoltage_threshold == 3'h2)
		else $error("overvoltage select reset wrong");

	a_dc_load: assert property ( // [R13]
		$stable(vrect_mv) && $stable(st_reg.ov_sel) |=>
			dc_load_en == (32'($past(vrect_mv)) * 10 >=
			32'($past(ov_mv)) * 9))
		else $error("extra load switch point wrong");

	a_chg_none: assert property ( // [R14]
		st_reg.cmd[`WRX_CMD_CSP] && charge_value == `WRX_CHG_NONE &&
		!host_bus.wr_en |=> !st_reg.cmd[`WRX_CMD_CSP])
		else $error("no-report charge value not dropped");

endmodule

// File: shared/wrx_defs.svh
// Functional notes
// R1: Coil AC frequency in kHz reads back as a 16-bit read-only value.
// R2: Mode field reads 00 with no AC input, 01 in WPC mode.
// R3: Bit 0 of the mode register shows whether the regulated output is on.
// R4: Command bit 5 clears selected pending interrupts, then self-clears.
// R5: Command bit 4 sends a charge status packet, then self-clears.
// R6: Command bit 3 sends an end-of-power packet with stored reason, then clears.
// R7: Command bit 1 inverts the regulated output exactly once, then clears.
// R8: Command bit 0 sends stored command and value as proprietary packet.
// R9: Packet order: received power, charge status, proprietary, control error.
// R10: Host sends charge status or proprietary at most once per 250 ms.
// R11: Die temperature is a 12-bit code; upper four bits read zero.
// R12: Overvoltage code selects 17, 20, 15, 13 or 11 V; resets to 2.
// R13: Extra DC load switches in at 90 percent of overvoltage level.
// R14: Charge value 1 to 100 is percent; 0xFF means no reporting.
// R15: End-of-power reason codes 0 to 8; anything above is sent as unknown.
// R16: Host waits for a command bit to read zero before setting it again.
`ifndef WRX_DEFS_SVH
`define WRX_DEFS_SVH

// ============================================================
// Register byte addresses
`define WRX_ADDR_FREQ_L   8'h48
`define WRX_ADDR_FREQ_H   8'h49
`define WRX_ADDR_MODE     8'h4C
`define WRX_ADDR_CMD      8'h4E
`define WRX_ADDR_TEMP_L   8'h66
`define WRX_ADDR_TEMP_H   8'h67
`define WRX_ADDR_OV       8'hB3

// ============================================================
// Command bit positions and write mask
`define WRX_CMD_CLR_INT   5
`define WRX_CMD_CSP       4
`define WRX_CMD_EPT       3
`define WRX_CMD_TOGGLE    1
`define WRX_CMD_PPP       0
`define WRX_CMD_WMASK     8'h3F
`define WRX_CMD_RST       8'h00

// ============================================================
// Mode field
`define WRX_MODE_AC_MISSING 2'h0
`define WRX_MODE_WPC        2'h1

// ============================================================
// Overvoltage levels in mV and the load switch ratio
`define WRX_OV_RST        3'h2
`define WRX_OV_MV_0       16'h4268
`define WRX_OV_MV_1       16'h4E20
`define WRX_OV_MV_2       16'h3A98
`define WRX_OV_MV_3       16'h32C8
`define WRX_OV_MV_LOW     16'h2AF8
`define WRX_DCL_NUM       20'h00009
`define WRX_DCL_DEN       20'h0000A

// ============================================================
// Packet payload codes
`define WRX_CHG_MIN       8'h01
`define WRX_CHG_MAX       8'h64
`define WRX_CHG_NONE      8'hFF
`define WRX_EPT_MAX       8'h08
`define WRX_EPT_UNKNOWN   8'h00

// ============================================================
// Request slots, slot 0 wins
`define WRX_REQ_EPT       0
`define WRX_REQ_RPP       1
`define WRX_REQ_CSP       2
`define WRX_REQ_PPP       3
`define WRX_REQ_CEP       4
`define WRX_REQ_N         5

`endif

// File: shared/wrx_pkg.sv
package wrx_pkg;

	// ============================================================
	// Enumerations
	typedef enum logic [2:0] {
		PK_NONE = 3'b000,
		PK_EPT  = 3'b001,
		PK_RPP  = 3'b010,
		PK_CSP  = 3'b011,
		PK_PPP  = 3'b100,
		PK_CEP  = 3'b101
	} wrx_pkt_e;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_BUSY = 1'b1
	} wrx_tx_st_e;

	// ============================================================
	// Carriers
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wrx_host_bus_s;

	typedef struct packed {
		logic       valid;
		wrx_pkt_e   kind;
		logic [7:0] hdr;
		logic [7:0] pay;
	} wrx_tx_pkt_s;

	typedef struct packed {
		logic [7:0]  cmd;
		logic        out_on;
		logic [2:0]  ov_sel;
		logic [7:0]  rdata;
		logic        int_clr;
		logic        rpp_ack;
		logic        cep_ack;
		logic        dc_load;
		wrx_tx_st_e  tx_st;
		wrx_tx_pkt_s tx;
	} wrx_state_s;

endpackage

// File: tb/wrx_regs_bench.sv
module wrx_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import wrx_pkg::*;

	logic          core_clk, sys_rst, ac_present, rpp_req, cep_req;
	logic          tx_ready, output_active_flag, dc_load_en, int_clear_go;
	logic          rpp_ack, cep_ack;
	wrx_host_bus_s host_bus;
	wrx_tx_pkt_s   tx_pkt;
	logic [7:0]    host_rdata, charge_value, ept_reason, prop_cmd;
	logic [7:0]    prop_value, rpp_value, cep_value, n_got, n_ack;
	logic [15:0]   coil_freq_khz, vrect_mv;
	logic [11:0]   die_temp_code;
	logic [2:0]    overvoltage_threshold;
	logic [3:0]    dly;
	logic [15:0]   lvl [0:7];
	wrx_pkt_e      exp_k [0:4];
	int            num_errors, comparisons, n;

	wrx_regs u_wrx_regs (.core_clk(core_clk), .sys_rst(sys_rst),
		.host_bus(host_bus), .host_rdata(host_rdata),
		.coil_freq_khz(coil_freq_khz), .ac_present(ac_present),
		.die_temp_code(die_temp_code), .vrect_mv(vrect_mv),
		.charge_value(charge_value), .ept_reason(ept_reason),
		.prop_cmd(prop_cmd), .prop_value(prop_value),
		.rpp_req(rpp_req), .rpp_value(rpp_value), .cep_req(cep_req),
		.cep_value(cep_value), .rpp_ack(rpp_ack), .cep_ack(cep_ack),
		.tx_pkt(tx_pkt), .tx_ready(tx_ready),
		.output_active_flag(output_active_flag), .dc_load_en(dc_load_en),
		.overvoltage_threshold(overvoltage_threshold),
		.int_clear_go(int_clear_go));

	wrx_tx_model u_wrx_tx_model (.core_clk(core_clk), .sys_rst(sys_rst),
		.tx_pkt(tx_pkt), .tx_ready(tx_ready), .dly(dly), .n_got(n_got));

	// ============================================================
	// Clock and firmware request release
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Firmware drops its request once the packet was taken
	always @(negedge core_clk) begin
		if (rpp_ack) rpp_req <= 1'b0;
		if (cep_ack) cep_req <= 1'b0;
		// Counted per falling edge, so a stretched ack shows up as extra
		n_ack <= n_ack + {7'h00, rpp_ack} + {7'h00, cep_ack};
	end

	// ============================================================
	// Host access and checking
	task automatic give_verdict();
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		host_bus = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(negedge core_clk);
		host_bus.wr_en = 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		host_bus = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
		@(negedge core_clk);
		host_bus.rd_en = 1'b0;
		chk({8'h00, host_rdata}, {8'h00, exp});
	endtask

	// Bounded wait for the transmitter to have taken cnt packets
	task automatic wait_pkts(input int cnt);
		for (int i = 0; i < 200 && n_got < cnt; i++) @(negedge core_clk);
		if (n_got < cnt) begin
			num_errors++;
			give_verdict();
		end
		repeat (2) @(negedge core_clk);
	endtask

	task automatic send(input logic [7:0] c, input wrx_pkt_e k,
		input logic [7:0] h, input logic [7:0] p);
		wr(8'h4E, c);
		n = n_got + 1;
		wait_pkts(n);
		chk({13'h0000, u_wrx_tx_model.log[n-1].kind}, {13'h0000, k});
		chk({8'h00, u_wrx_tx_model.log[n-1].hdr}, {8'h00, h});
		chk({8'h00, u_wrx_tx_model.log[n-1].pay}, {8'h00, p});
		rd_chk(8'h4E, 8'h00);
	endtask

	// ============================================================
	// Main sequence
	initial begin
		host_bus = '0;
		sys_rst = 1'b1;
		{ac_present, rpp_req, cep_req, dly, vrect_mv} = '0;
		{coil_freq_khz, die_temp_code} = {16'hABCD, 12'hFFF};
		{charge_value, ept_reason, prop_cmd} = {8'h32, 8'h04, 8'h5A};
		{prop_value, rpp_value, cep_value} = {8'hC3, 8'h11, 8'h22};
		lvl = '{16'h3BC4, 16'h4650, 16'h34BC, 16'h2DB4,
			16'h26AC, 16'h26AC, 16'h26AC, 16'h26AC};
		exp_k = '{PK_EPT, PK_RPP, PK_CSP, PK_PPP, PK_CEP};
		num_errors = 0;
		n_ack = 8'h00;
		comparisons = 0;
		repeat (12) @(negedge core_clk);
		sys_rst = 1'b0;
		chk({15'h0000, output_active_flag}, 16'h0000);
		chk({13'h0000, overvoltage_threshold}, 16'h0002);
		wr(8'h48, 8'h00);
		rd_chk(8'h48, 8'hCD);
		rd_chk(8'h49, 8'hAB);
		rd_chk(8'h4C, 8'h00);
		ac_present = 1'b1;
		rd_chk(8'h4C, 8'h20);
		rd_chk(8'h66, 8'hFF);
		rd_chk(8'h67, 8'h0F);
		rd_chk(8'hB3, 8'h02);
		rd_chk(8'h50, 8'h00);
		for (int i = 0; i < 2; i++) begin
			wr(8'h4E, 8'h02);
			@(negedge core_clk);
			chk({15'h0000, output_active_flag}, (i == 0) ? 16'h1 : 16'h0);
			rd_chk(8'h4C, (i == 0) ? 8'h21 : 8'h20);
			rd_chk(8'h4E, 8'h00);
		end
		wr(8'h4C, 8'h01);
		chk({15'h0000, output_active_flag}, 16'h0001);
		rd_chk(8'h4C, 8'h21);
		wr(8'h4C, 8'h00);
		rd_chk(8'h4C, 8'h20);
		wr(8'h4E, 8'hC0);
		rd_chk(8'h4E, 8'h00);
		wr(8'h4E, 8'h20);
		@(negedge core_clk);
		chk({15'h0000, int_clear_go}, 16'h0001);
		@(negedge core_clk);
		chk({15'h0000, int_clear_go}, 16'h0000);
		rd_chk(8'h4E, 8'h00);
		send(8'h10, PK_CSP, 8'h00, 8'h32);
		send(8'h08, PK_EPT, 8'h00, 8'h04);
		ept_reason = 8'h09;
		send(8'h08, PK_EPT, 8'h00, 8'h00);
		dly = 4'h3;
		// Host paces requests by completion only, far faster than once per 250 ms
		send(8'h01, PK_PPP, 8'h5A, 8'hC3);
		charge_value = 8'hFF;
		n = n_got;
		wr(8'h4E, 8'h10);
		repeat (6) @(negedge core_clk);
		chk({8'h00, n_got}, n[15:0]);
		rd_chk(8'h4E, 8'h00);
		// Everything pending at once, transmitter stalling each packet
		{dly, ept_reason, charge_value} = {4'h2, 8'h01, 8'h64};
		wr(8'h4E, 8'h19);
		rpp_req = 1'b1;
		cep_req = 1'b1;
		n = n_got;
		wait_pkts(n + 5);
		for (int j = 0; j < 5; j++)
			chk({13'h0000, u_wrx_tx_model.log[n+j].kind},
				{13'h0000, exp_k[j]});
		chk({8'h00, u_wrx_tx_model.log[n+1].pay}, 16'h0011);
		chk({8'h00, u_wrx_tx_model.log[n+4].pay}, 16'h0022);
		chk({8'h00, n_ack}, 16'h0002);
		// Load threshold at 90 percent of every overvoltage code
		for (int c = 0; c < 8; c++) begin
			wr(8'hB3, c[7:0]);
			rd_chk(8'hB3, c[7:0]);
			chk({13'h0000, overvoltage_threshold}, c[15:0]);
			vrect_mv = lvl[c] - 16'h0001;
			repeat (3) @(negedge core_clk);
			chk({15'h0000, dc_load_en}, 16'h0000);
			vrect_mv = lvl[c];
			repeat (3) @(negedge core_clk);
			chk({15'h0000, dc_load_en}, 16'h0001);
		end
		give_verdict();
	end
endmodule

// File: tb/wrx_tx_model.sv
module wrx_tx_model (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	// Transmitter link
	input  wire wrx_pkg::wrx_tx_pkt_s tx_pkt,
	output logic                      tx_ready,
	// Stall length and count of packets taken
	input  wire logic [3:0]           dly,
	output logic [7:0]                n_got
);
	timeunit 1ns;
	timeprecision 100ps;
	import wrx_pkg::*;

	wrx_tx_pkt_s log [0:31];
	logic [3:0]  cnt;

	initial begin
		tx_ready = 1'b0;
		cnt = 4'h0;
		n_got = 8'h00;
	end

	// ============================================================
	// Acceptance: stall dly cycles, then ready for exactly one cycle
	always @(negedge core_clk) begin
		if (sys_rst || !tx_pkt.valid || tx_ready) begin
			tx_ready <= 1'b0;
			cnt <= 4'h0;
		end else if (cnt >= dly) begin
			tx_ready <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end

	// ============================================================
	// Log in arrival order so the bench can judge priority
	always @(posedge core_clk) begin
		if (sys_rst) begin
			n_got <= 8'h00;
		end else if (tx_pkt.valid && tx_ready) begin
			log[n_got[4:0]] <= tx_pkt;
			n_got <= n_got + 8'h01;
		end
	end
endmodule
